// >>> rtl/flash_bus_access.v
/*
  Bus access control between the cpu core and the flash, internal ram
  and peripheral ports: width splitting, fetch/data serialisation,
  flash read waits, protection, wait and vector base registers.
  Assumes the cpu holds each request until its ready pulse, memories
  answer reads within the strobe cycle, and dbg_unprotect is on clk.
*/
`timescale 1ns/1ns
`include "flash_bus_map.vh"

// What this block does
// [R1] each bus beat takes one clock; flash read beats add the wait count
// [R2] split accesses by device width
// [R3] 32-bit write zeroes top byte, read drops it
// [R4] stack word carries status byte and address
// [R5] same-memory fetch waits for data beats
// [R6] flash decoded 0x8000-0xbfff, four 4kB sectors
// [R7] vector base resets 0x8000, low/high registers
// [R8] write protect blocks writes and erase, except erase of sector 3
// [R9] read protect zeroes data reads, not fetches
// [R10] zero bit protects; only debug lifts it
// [R11] write-protect word bits D3-D0 per area
// [R12] read-protect word bits D3-D1 per area
// [R13] software keeps read-protect D0 set
// [R14] two-bit flash wait count, reset three
// [R15] software picks wait count for clock
// [R16] software matches access size to device
// [R17] capture protect words after reset, apply always
module flash_bus_access (
  input  wire        clk,           // system clock, 10 MHz
  input  wire        srst,          // sync reset, active high
  input  wire        if_req,        // instruction fetch request
  input  wire [23:0] if_addr,       // fetch address
  output wire        if_ready,      // fetch done pulse
  output wire [15:0] if_rdata,      // fetched halfword
  input  wire        d_req,         // data access request
  input  wire        d_we,          // data write
  input  wire        d_erase,       // sector erase
  input  wire        d_stack,       // interrupt stack push or pop
  input  wire [1:0]  d_size,        // 0 byte, 1 half, 2 word
  input  wire [23:0] d_addr,        // data address
  input  wire [23:0] d_wdata,       // general register value
  input  wire [7:0]  d_psr,         // processor status byte
  output wire        d_ready,       // data done pulse
  output wire [31:0] d_rdata,       // read data
  output wire        d_blocked,     // write or erase was refused
  output wire [23:0] fl_addr,       // flash address
  output wire        fl_rd,         // flash read strobe
  output wire        fl_wr,         // flash write strobe
  output wire        fl_erase,      // flash sector erase strobe
  output wire [15:0] fl_wdata,      // flash write data
  input  wire [15:0] fl_rdata,      // flash read data
  output wire [23:0] ram_addr,      // ram address
  output wire        ram_rd,        // ram read strobe
  output wire        ram_wr,        // ram write strobe
  output wire [3:0]  ram_be,        // ram byte enables
  output wire [31:0] ram_wdata,     // ram write data
  input  wire [31:0] ram_rdata,     // ram read data
  output wire [23:0] per_addr,      // peripheral address
  output wire        per_rd,        // peripheral read strobe
  output wire        per_wr,        // peripheral write strobe
  output wire [15:0] per_wdata,     // peripheral write data
  input  wire [15:0] per_rdata,     // peripheral read data
  input  wire        dbg_unprotect, // debugger lifts protection
  output wire [23:0] vector_base,   // vector table base
  output wire [1:0]  flash_read_wait_count, // flash wait setting
  output wire [3:0]  prot_wp,       // captured write-protect bits
  output wire [3:0]  prot_rp        // captured read-protect bits
);

  // ================================================================
  // decode helpers
  function [1:0] region;
    input [23:0] a;
    begin
      if (a <= `RAM_LAST)
        region = `RG_RAM;
      else if (a >= `FLASH_BASE && a <= `FLASH_LAST)
        region = `RG_FLASH; // [R6]
      else if (a >= `PER1_BASE && a <= `PER1_LAST)
        region = `RG_PER;
      else if (a >= `PER2_BASE && a <= `PER2_LAST)
        region = `RG_PER;
      else
        region = `RG_NONE;
    end
  endfunction

  function [1:0] dev_width;
    input [23:0] a;
    begin
      if (a <= `RAM_LAST)
        dev_width = `W32;
      else if (a >= `PER1_BASE && a <= `PER1_BYTE_LAST)
        dev_width = `W8;
      else if (a >= `PER2_BASE && a <= `PER2_BYTE_LAST)
        dev_width = `W8;
      else
        dev_width = `W16;
    end
  endfunction

  // ================================================================
  // state
  reg  [2:0]  st_q;
  reg  [23:0] a_q;
  reg  [1:0]  idx_q;
  reg  [1:0]  size_q;
  reg  [1:0]  rg_q;
  reg  [1:0]  wd_q;
  reg         we_q;
  reg         er_q;
  reg         stk_q;
  reg  [31:0] wdata_q;
  reg  [31:0] acc_q;
  reg  [1:0]  wcnt_q;
  reg         blk_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rdwait_q;
  reg  [15:0] vec_lo_q;
  reg  [7:0]  vec_hi_q;
  reg  [1:0]  f_st_q;
  reg  [23:0] f_addr_q;
  reg  [1:0]  f_rg_q;
  reg  [1:0]  f_wcnt_q;
  reg  [15:0] if_rdata_q;

  wire [2:0]  beats;
  wire [31:0] piece;
  wire [31:0] acc_out;
  wire        write_block;
  wire        erase_block;
  wire        read_zero;
  reg  [31:0] beat_rd;
  reg  [15:0] reg_rd;
  reg  [31:0] final_rd;

  wire boot = (st_q == `S_BOOTW) || (st_q == `S_BOOTR);
  wire in_beat = (st_q == `S_BEAT);
  wire is_fl = (rg_q == `RG_FLASH);
  wire reg_hit = (rg_q == `RG_PER) && ((a_q == `WAIT_REG_ADDR) ||
                 (a_q == `VEC_LO_ADDR) || (a_q == `VEC_HI_ADDR));
  wire d_rd = ~we_q & ~er_q;

  // flash reads hold the beat for the wait count; all else one clock
  wire beat_end = ~is_fl | ~d_rd | (wcnt_q == rdwait_q); // [R1] [R14]
  wire last_beat = ({1'b0, idx_q} == beats - 3'd1);
  wire boot_end = (wcnt_q == rdwait_q); // [R14]

  // ================================================================
  // fetch against data arbitration
  wire [1:0] d_new_rg = region(d_addr);
  wire [1:0] f_new_rg = region(if_addr);
  wire f_busy = (f_st_q == `F_BUSY);
  // ram and flash are single ported; peripherals never hold code
  wire d_start = (st_q == `S_IDLE) & d_req &
                 ~(f_busy & (f_rg_q == d_new_rg)); // [R5]
  wire f_start = (f_st_q == `F_IDLE) & if_req & ~boot &
                 ~(in_beat & (rg_q == f_new_rg)) &
                 ~(d_start & (d_new_rg == f_new_rg)); // [R5]
  wire f_end = (f_rg_q != `RG_FLASH) | (f_wcnt_q == rdwait_q); // [R14]

  access_splitter u_split (
    .size       (size_q),
    .width      (wd_q),
    .idx        (idx_q),
    .wdata      (wdata_q),
    .beat_rdata (beat_rd),
    .acc_in     (acc_q),
    .beats      (beats),
    .piece      (piece),
    .acc_out    (acc_out)
  );

  protect_filter u_prot (
    .clk           (clk),
    .srst          (srst),
    .load_wp       ((st_q == `S_BOOTW) & boot_end),
    .load_rp       ((st_q == `S_BOOTR) & boot_end),
    .word_in       (fl_rdata),
    .dbg_unprotect (dbg_unprotect),
    .addr          (a_q),
    .in_flash      (is_fl),
    .write_block   (write_block),
    .erase_block   (erase_block),
    .read_zero     (read_zero),
    .wp_bits       (prot_wp),
    .rp_bits       (prot_rp)
  );

  wire blk_now = (we_q & write_block) | (er_q & erase_block); // [R8]

  // ================================================================
  // beat read data, low aligned
  always @* begin
    case (a_q)
      `WAIT_REG_ADDR: reg_rd = {14'h0000, rdwait_q};
      `VEC_LO_ADDR:   reg_rd = vec_lo_q;
      default:        reg_rd = {8'h00, vec_hi_q};
    endcase
    case (rg_q)
      `RG_RAM:   beat_rd = ram_rdata >> {a_q[1:0], 3'b000};
      `RG_FLASH: beat_rd = read_zero ? 32'h00000000
                                     : {16'h0000, fl_rdata}; // [R9]
      `RG_PER:   beat_rd = reg_hit ? {16'h0000, reg_rd}
                                   : {16'h0000, per_rdata};
      default:   beat_rd = 32'h00000000;
    endcase
    // a byte from the odd half of a 16-bit device
    if (wd_q == `W16 && size_q == `SZ8 && a_q[0])
      beat_rd = beat_rd >> 8;
    case (size_q)
      `SZ8:    final_rd = {24'h000000, acc_out[7:0]};
      `SZ16:   final_rd = {16'h0000, acc_out[15:0]};
      default: final_rd = stk_q ? acc_out // [R4]
                                : {8'h00, acc_out[23:0]}; // [R3]
    endcase
  end

  // ================================================================
  // data sequencer
  always @(posedge clk) begin
    if (srst) begin
      st_q    <= `S_BOOTW;
      a_q     <= `WP_WORD_ADDR;
      idx_q   <= 2'h0;
      size_q  <= `SZ16;
      rg_q    <= `RG_FLASH;
      wd_q    <= `W16;
      we_q    <= 1'b0;
      er_q    <= 1'b0;
      stk_q   <= 1'b0;
      wdata_q <= 32'h00000000;
      acc_q   <= 32'h00000000;
      wcnt_q  <= 2'h0;
      blk_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      case (st_q)
        `S_BOOTW: begin
          wcnt_q <= wcnt_q + 2'h1;
          if (boot_end) begin
            wcnt_q <= 2'h0;
            a_q    <= `RP_WORD_ADDR; // [R17]
            st_q   <= `S_BOOTR;
          end
        end
        `S_BOOTR: begin
          wcnt_q <= wcnt_q + 2'h1;
          if (boot_end) begin
            wcnt_q <= 2'h0;
            st_q   <= `S_IDLE;
          end
        end
        `S_IDLE: begin
          if (d_start) begin
            a_q    <= d_addr;
            size_q <= d_erase ? `SZ8 : d_size;
            rg_q   <= d_new_rg;
            wd_q   <= dev_width(d_addr);
            we_q   <= d_we & ~d_erase;
            er_q   <= d_erase;
            stk_q  <= d_stack;
            // stack frames keep the status byte above the address
            wdata_q <= d_stack ? {d_psr, d_wdata} // [R4]
                               : {8'h00, d_wdata}; // [R3]
            idx_q  <= 2'h0;
            acc_q  <= 32'h00000000;
            wcnt_q <= 2'h0;
            blk_q  <= 1'b0;
            st_q   <= `S_BEAT;
          end
        end
        `S_BEAT: begin
          wcnt_q <= wcnt_q + 2'h1;
          if (beat_end) begin
            wcnt_q <= 2'h0;
            acc_q  <= acc_out;
            blk_q  <= blk_q | blk_now;
            if (last_beat) begin
              rdata_q <= final_rd;
              st_q    <= `S_DONE;
            end else begin
              idx_q <= idx_q + 2'h1; // [R2]
              a_q   <= a_q + ({21'h000000, 3'd1} << wd_q);
            end
          end
        end
        `S_DONE: st_q <= `S_IDLE;
        default: st_q <= `S_IDLE;
      endcase
    end
  end

  // ================================================================
  // wait and vector base registers, served on the peripheral beat
  wire reg_wr = in_beat & reg_hit & we_q;

  always @(posedge clk) begin
    if (srst) begin
      rdwait_q <= `WAIT_RST; // [R14]
      {vec_hi_q, vec_lo_q} <= `VEC_RST; // [R7]
    end else if (reg_wr) begin
      if (a_q == `WAIT_REG_ADDR)
        rdwait_q <= piece[`WAIT_MSB:`WAIT_LSB]; // [R14]
      if (a_q == `VEC_LO_ADDR)
        vec_lo_q <= piece[15:0]; // [R7]
      if (a_q == `VEC_HI_ADDR)
        vec_hi_q <= piece[7:0];
    end
  end

  // ================================================================
  // fetch sequencer; fetches ignore read protection
  always @(posedge clk) begin
    if (srst) begin
      f_st_q     <= `F_IDLE;
      f_addr_q   <= 24'h000000;
      f_rg_q     <= `RG_NONE;
      f_wcnt_q   <= 2'h0;
      if_rdata_q <= 16'h0000;
    end else begin
      case (f_st_q)
        `F_IDLE: begin
          if (f_start) begin
            f_addr_q <= if_addr;
            f_rg_q   <= f_new_rg;
            f_wcnt_q <= 2'h0;
            f_st_q   <= `F_BUSY;
          end
        end
        `F_BUSY: begin
          f_wcnt_q <= f_wcnt_q + 2'h1;
          if (f_end) begin
            case (f_rg_q)
              `RG_FLASH: if_rdata_q <= fl_rdata; // [R9]
              `RG_RAM:   if_rdata_q <= f_addr_q[1] ? ram_rdata[31:16]
                                                   : ram_rdata[15:0];
              default:   if_rdata_q <= 16'h0000;
            endcase
            f_st_q <= `F_DONE;
          end
        end
        `F_DONE: f_st_q <= `F_IDLE;
        default: f_st_q <= `F_IDLE;
      endcase
    end
  end

  // ================================================================
  // memory ports
  wire f_fl = f_busy & (f_rg_q == `RG_FLASH);
  wire f_ram = f_busy & (f_rg_q == `RG_RAM);
  wire d_fl = in_beat & is_fl;
  wire d_ram = in_beat & (rg_q == `RG_RAM);
  wire d_per = in_beat & (rg_q == `RG_PER) & ~reg_hit;
  wire [15:0] w16 = (size_q == `SZ8) ? {piece[7:0], piece[7:0]}
                                     : piece[15:0];
  wire [3:0] be_sz = (size_q == `SZ8) ? 4'h1 :
                     (size_q == `SZ16) ? 4'h3 : 4'hf;

  assign fl_addr  = f_fl ? f_addr_q : a_q;
  assign fl_rd    = f_fl | boot | (d_fl & d_rd);
  assign fl_wr    = d_fl & we_q & ~write_block; // [R8]
  assign fl_erase = d_fl & er_q & ~erase_block; // [R8]
  assign fl_wdata = w16;

  assign ram_addr  = f_ram ? f_addr_q : a_q;
  assign ram_rd    = f_ram | (d_ram & d_rd);
  assign ram_wr    = d_ram & we_q;
  assign ram_be    = be_sz << a_q[1:0];
  assign ram_wdata = piece << {a_q[1:0], 3'b000};

  assign per_addr  = a_q;
  assign per_rd    = d_per & d_rd;
  assign per_wr    = d_per & we_q;
  assign per_wdata = w16;

  // ================================================================
  // cpu side outputs
  assign d_ready   = (st_q == `S_DONE);
  assign d_rdata   = rdata_q;
  assign d_blocked = d_ready & blk_q;
  assign if_ready  = (f_st_q == `F_DONE);
  assign if_rdata  = if_rdata_q;
  assign vector_base = {vec_hi_q, vec_lo_q}; // [R7]
  assign flash_read_wait_count = rdwait_q;

endmodule // flash_bus_access

// >>> shared/flash_bus_map.vh
/*
  Address map, reset values and state codes for the flash bus access
  control block. Included by every design file; holds definitions only.
*/
`ifndef FLASH_BUS_MAP_VH
`define FLASH_BUS_MAP_VH

// ==================================================================
// address map (24-bit byte addresses)
`define RAM_LAST        24'h0007ff
`define PER1_BASE       24'h004000
`define PER1_BYTE_LAST  24'h0040ff
`define PER1_LAST       24'h0043ff
`define PER2_BASE       24'h005000
`define PER2_BYTE_LAST  24'h0052ff
`define PER2_LAST       24'h005fff
`define FLASH_BASE      24'h008000
`define FLASH_LAST      24'h00bfff
`define WP_WORD_ADDR    24'h00bffc
`define RP_WORD_ADDR    24'h00bffe
`define WAIT_REG_ADDR   24'h0054b0
`define VEC_LO_ADDR     24'h005320
`define VEC_HI_ADDR     24'h005322

// ==================================================================
// reset values and field positions
`define WAIT_RST        2'h3
`define VEC_RST         24'h008000
`define PROT_RST        4'hf
`define PROT_SECTOR     2'h3
`define WAIT_LSB        0
`define WAIT_MSB        1

// ==================================================================
// region, width and size codes
`define RG_RAM          2'h0
`define RG_PER          2'h1
`define RG_FLASH        2'h2
`define RG_NONE         2'h3
`define W8              2'h0
`define W16             2'h1
`define W32             2'h2
`define SZ8             2'h0
`define SZ16            2'h1
`define SZ32            2'h2

// ==================================================================
// state codes
`define S_BOOTW         3'h0
`define S_BOOTR         3'h1
`define S_IDLE          3'h2
`define S_BEAT          3'h3
`define S_DONE          3'h4
`define F_IDLE          2'h0
`define F_BUSY          2'h1
`define F_DONE          2'h2

`endif

// >>> rtl/access_splitter.v
/*
  Splits one CPU access into device-width beats: beat count, write
  lane for the current beat, and read assembly into an accumulator.
  Purely combinational; the caller sequences the beat index.
*/
`timescale 1ns/1ns
`include "flash_bus_map.vh"

module access_splitter (
  input  wire [1:0]  size,       // cpu access size code
  input  wire [1:0]  width,      // device width code
  input  wire [1:0]  idx,        // current beat index
  input  wire [31:0] wdata,      // whole write word
  input  wire [31:0] beat_rdata, // beat read data, low aligned
  input  wire [31:0] acc_in,     // read data gathered so far
  output wire [2:0]  beats,      // beats for this access
  output wire [31:0] piece,      // write data of current beat
  output wire [31:0] acc_out     // accumulator after this beat
);

  function [2:0] bytes_of;
    input [1:0] c;
    begin
      case (c)
        2'h0:    bytes_of = 3'd1;
        2'h1:    bytes_of = 3'd2;
        default: bytes_of = 3'd4;
      endcase
    end
  endfunction

  function [31:0] mask_of;
    input [1:0] c;
    begin
      case (c)
        2'h0:    mask_of = 32'h000000ff;
        2'h1:    mask_of = 32'h0000ffff;
        default: mask_of = 32'hffffffff;
      endcase
    end
  endfunction

  wire [2:0] req_b;
  wire [4:0] sh;

  assign req_b = bytes_of(size);
  // a narrow device needs one beat per device-sized slice
  assign beats = (size > width) ? (req_b >> width) : 3'd1; // [R2]
  assign sh = {idx, 3'b000} << width;
  assign piece = (wdata >> sh) & mask_of(width);
  assign acc_out = acc_in | ((beat_rdata & mask_of(width)) << sh);

endmodule // access_splitter

// >>> rtl/protect_filter.v
/*
  Holds the write-protect and read-protect words captured from flash
  and judges each flash data access against them.
  Assumes the caller loads both words once after reset.
*/
`timescale 1ns/1ns
`include "flash_bus_map.vh"

module protect_filter (
  input  wire        clk,           // system clock
  input  wire        srst,          // sync reset, active high
  input  wire        load_wp,       // capture write-protect word
  input  wire        load_rp,       // capture read-protect word
  input  wire [15:0] word_in,       // word read from flash
  input  wire        dbg_unprotect, // debug path lifts protection
  input  wire [23:0] addr,          // address being accessed
  input  wire        in_flash,      // address lies in flash
  output wire        write_block,   // data write refused
  output wire        erase_block,   // sector erase refused
  output wire        read_zero,     // data read returns zero
  output wire [3:0]  wp_bits,       // captured write-protect bits
  output wire [3:0]  rp_bits        // captured read-protect bits
);

  reg  [3:0] wp_q;
  reg  [3:0] rp_q;
  wire [1:0] area;

  // 4 kB area index inside the flash window
  assign area = addr[13:12];

  always @(posedge clk) begin
    if (srst) begin
      wp_q <= `PROT_RST; // [R11] [R12]
      rp_q <= `PROT_RST;
    end else begin
      if (load_wp)
        wp_q <= word_in[3:0]; // [R11] [R17]
      // area at the base has no read-protect bit of its own
      if (load_rp)
        rp_q <= {word_in[3:1], 1'b1}; // [R12] [R17]
    end
  end

  // only the debug path can lift a zero bit; software has no way in
  assign write_block = in_flash & ~dbg_unprotect & ~wp_q[area]; // [R10] [R8]
  assign erase_block = write_block & (area != `PROT_SECTOR); // [R8]
  assign read_zero = in_flash & ~dbg_unprotect & ~rp_q[area]; // [R9] [R10]
  assign wp_bits = wp_q;
  assign rp_bits = rp_q;

endmodule // protect_filter

// >>> verification/flash_bus_access_asserts.sv
/* port checker for flash_bus_access.
   bound to the design by module name; sees its ports only. */
`timescale 1ns/1ns
module flash_bus_access_asserts (
  input wire        clk,           // clock
  input wire        srst,          // reset
  input wire [1:0]  d_size,        // size
  input wire        d_we,          // write
  input wire        d_stack,       // stack op
  input wire [7:0]  d_psr,         // status
  input wire        d_ready,       // done
  input wire        d_blocked,     // refused
  input wire [31:0] d_rdata,       // read data
  input wire [23:0] fl_addr,       // flash addr
  input wire        fl_rd,         // flash rd
  input wire        fl_wr,         // flash wr
  input wire        fl_erase,      // erase
  input wire        ram_wr,        // ram wr
  input wire [31:0] ram_wdata,     // ram data
  input wire        per_wr,        // per wr
  input wire [23:0] per_addr,      // per addr
  input wire        dbg_unprotect, // debug
  input wire [23:0] vector_base,   // vectors
  input wire [1:0]  flash_read_wait_count, // wait
  input wire [3:0]  prot_wp        // wp bits
);
  // ====================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  rst_vals_a: assert property (disable iff (1'b0) srst |=>
    vector_base == 24'h008000 && flash_read_wait_count == 2'h3)
    else $error("reset values");
  ram_beat_a: assert property (ram_wr |=> d_ready && !ram_wr)
    else $error("ram beat");
  wait_len_a: assert property ($rose(fl_rd) &&
    flash_read_wait_count == 2'h3 |-> fl_rd [*4]) else $error("wait");
  fl_range_a: assert property (fl_rd |-> fl_addr[23:14] == 10'h002)
    else $error("flash decode");
  wr_prot_a: assert property (fl_wr |-> dbg_unprotect ||
    prot_wp[fl_addr[13:12]]) else $error("write protect");
  er_prot_a: assert property (fl_erase |-> dbg_unprotect ||
    prot_wp[fl_addr[13:12]] || fl_addr[13:12] == 2'h3) else $error("erase");
  blk_ready_a: assert property (d_blocked |-> d_ready)
    else $error("blocked");
  rdy_pulse_a: assert property (d_ready |=> !d_ready)
    else $error("ready");
  rd_top_a: assert property (d_ready && !d_we && !d_stack &&
    d_size == 2'h2 |-> d_rdata[31:24] == 8'h00) else $error("read top");
  wr_top_a: assert property (ram_wr && d_size == 2'h2 |->
    ram_wdata[31:24] == (d_stack ? d_psr : 8'h00)) else $error("write top");
  byte_dev_a: assert property ($rose(per_wr) && d_size == 2'h1 &&
    per_addr == 24'h005000 |-> per_wr [*2] ##1 d_ready) else $error("beats");
  cover property (d_blocked);
  cover property (fl_erase);
  cover property (ram_wr && d_stack);
endmodule // flash_bus_access_asserts

bind flash_bus_access flash_bus_access_asserts i_chk (.*);

// >>> verification/mem_model.sv
/* flash, ram and peripheral model behind flash_bus_access.
   assumes the design strobes one beat per cycle. */
`timescale 1ns/1ns
module mem_model (
  input  wire        clk,       // clock
  input  wire [23:0] fl_addr,   // flash addr
  input  wire        fl_rd,     // flash rd
  input  wire        fl_wr,     // flash wr
  input  wire        fl_erase,  // erase
  input  wire [15:0] fl_wdata,  // flash data
  output wire [15:0] fl_rdata,  // flash out
  input  wire [23:0] ram_addr,  // ram addr
  input  wire        ram_rd,    // ram rd
  input  wire        ram_wr,    // ram wr
  input  wire [3:0]  ram_be,    // lanes
  input  wire [31:0] ram_wdata, // ram data
  output wire [31:0] ram_rdata, // ram out
  input  wire [23:0] per_addr,  // per addr
  input  wire        per_rd,    // per rd
  output wire [15:0] per_rdata  // per out
);
  reg [15:0] flash [0:8191];
  reg [31:0] ram [0:511];
  int i, j;
  initial begin
    for (i = 0; i < 8192; i++) flash[i] = i[15:0] ^ 16'h3c3c;
    for (i = 0; i < 512; i++) ram[i] = {i[15:0], ~i[15:0]};
    flash[8190] = 16'hffff;
    flash[8191] = 16'hffff;
  end
  // released lines show the inverse
  assign fl_rdata  = fl_rd ? flash[fl_addr[13:1]] : ~flash[fl_addr[13:1]];
  assign ram_rdata = ram_rd ? ram[ram_addr[10:2]] : ~ram[ram_addr[10:2]];
  assign per_rdata = {2{per_rd ? per_addr[7:0] : ~per_addr[7:0]}};
  always @(posedge clk) begin
    if (fl_wr) flash[fl_addr[13:1]] <= fl_wdata;
    if (fl_erase) for (j = 0; j < 2048; j++)
      flash[{fl_addr[13:12], j[10:0]}] <= 16'hffff;
    for (j = 0; j < 4; j++)
      if (ram_wr && ram_be[j])
        ram[ram_addr[10:2]][8*j +: 8] <= ram_wdata[8*j +: 8];
  end
endmodule // mem_model

// >>> verification/flash_bus_access_test.sv
/* self-checking bench for flash_bus_access.
   assumes mem_model and the bound checker are compiled first. */
`timescale 1ns/1ns
module flash_bus_access_test;
  reg         clk = 0, srst = 1, if_req = 0, d_req = 0, d_we = 0;
  reg         d_erase = 0, d_stack = 0, dbg_unprotect = 0, blk;
  reg  [1:0]  d_size = 0;
  reg  [7:0]  d_psr = 0;
  reg  [23:0] if_addr = 0, d_addr = 0, d_wdata = 0, a;
  reg  [31:0] rd, wd;
  reg  [15:0] fd;
  wire        if_ready, d_ready, d_blocked, fl_rd, fl_wr, fl_erase;
  wire        ram_rd, ram_wr, per_rd, per_wr;
  wire [15:0] if_rdata, fl_wdata, fl_rdata, per_wdata, per_rdata;
  wire [31:0] d_rdata, ram_wdata, ram_rdata;
  wire [23:0] fl_addr, ram_addr, per_addr, vector_base;
  wire [3:0]  ram_be, prot_wp, prot_rp;
  wire [1:0]  flash_read_wait_count;
  integer     num_errors = 0, checks = 0, cyc = 0, n, fn, i;
  flash_bus_access i_flash_bus_access (.*);
  mem_model i_mem_model (.*);
  always #50 clk = ~clk;
  // ====================
  // helpers
  function [15:0] fx(input [23:0] ad);
    fx = {3'h0, ad[13:1]} ^ 16'h3c3c;
  endfunction
  task chk(input [63:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task acc(input we, er, st, input [1:0] sz, input [23:0] ad, w);
    @(posedge clk);
    d_req   <= 1;
    d_we    <= we;
    d_erase <= er;
    d_stack <= st;
    d_size  <= sz;
    d_addr  <= ad;
    d_wdata <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (d_ready !== 1 && n < 300);
    d_req <= 0;
    rd  = d_rdata;
    blk = d_blocked;
  endtask
  task fetch(input [23:0] ad);
    @(posedge clk);
    if_req  <= 1;
    if_addr <= ad;
    fn = 0;
    do begin
      @(posedge clk);
      fn++;
    end while (if_ready !== 1 && fn < 300);
    if_req <= 0;
    fd = if_rdata;
  endtask
  task reset_dut;
    @(posedge clk);
    srst <= 1;
    repeat (16) @(posedge clk);
    srst <= 0;
    repeat (12) @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test;
    end
  end
  // ====================
  // tests
  initial begin
    wd = $urandom(32'hb0aa1ae3);
    reset_dut;
    chk(vector_base, 24'h008000);
    chk(prot_wp, 4'hf);
    acc(0, 0, 0, 1, 24'h0054b0, 0);
    chk(rd, 32'h3);
    acc(1, 0, 0, 1, 24'h005320, 24'h001234);
    chk(vector_base, 24'h001234);
    acc(0, 0, 0, 1, 24'h001000, 0);
    chk(rd, 0);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      acc(1, 0, 0, 1, 24'h0054b0, i);
      a = 24'h008000 + ($urandom & 24'h001ffc);
      acc(0, 0, 0, 1, a, 0);
      chk(rd, fx(a));
      chk(n, 3 + i);
      acc(0, 0, 0, 2, a, 0);
      chk(rd, {fx(a + 2), fx(a)} & 32'h00ffffff);
      chk(n, 4 + 2 * i);
    end
    $display("test wait done");
    for (i = 0; i < 16; i++) begin
      a = $urandom & 24'h0003fc;
      wd = $urandom;
      @(posedge clk) d_psr <= wd[31:24];
      if (!i[0]) wd[31:24] = 8'h00;
      acc(1, 0, i[0], 2, a, wd[23:0]);
      chk(n, 3);
      chk(i_mem_model.ram[a[10:2]], wd);
      acc(0, 0, 1, 2, a, 0);
      chk(rd, wd);
      acc(0, 0, 0, 2, a, 0);
      chk(rd, {8'h0, wd[23:0]});
    end
    $display("test ram done");
    acc(0, 0, 0, 1, 24'h005000, 0);
    chk({n, rd}, {32'd4, 32'h0100});
    acc(0, 0, 0, 2, 24'h005000, 0);
    chk({n, rd}, {32'd6, 32'h020100});
    acc(0, 0, 0, 2, 24'h004200, 0);
    chk({n, rd}, {32'd4, 32'h020000});
    acc(1, 0, 0, 1, 24'h005000, 24'h00beef);
    chk(n, 4);
    $display("test peripheral done");
    fork
      acc(0, 0, 0, 1, 24'h008100, 0);
      fetch(24'h008200);
    join
    chk(fn > n, 1);
    chk(fd, fx(24'h008200));
    fork
      acc(0, 0, 0, 1, 24'h008100, 0);
      fetch(24'h000400);
    join
    chk({fn, fd}, {32'd3, 16'hfeff});
    $display("test fetch done");
    acc(1, 0, 0, 1, 24'h00bffc, 24'h00fff5);
    acc(1, 0, 0, 1, 24'h00bffe, 24'h00fffb);
    reset_dut;
    chk({prot_wp, prot_rp[3:1]}, {4'h5, 3'h5});
    acc(1, 0, 0, 1, 24'h009010, 24'h001234);
    chk({blk, i_mem_model.flash[12'h808]}, {1'b1, fx(24'h009010)});
    acc(0, 1, 0, 1, 24'h009000, 0);
    chk({blk, i_mem_model.flash[12'h800]}, {1'b1, fx(24'h009000)});
    acc(0, 0, 0, 1, 24'h00a020, 0);
    chk(rd, 0);
    fetch(24'h00a020);
    chk(fd, fx(24'h00a020));
    @(posedge clk) dbg_unprotect <= 1;
    acc(0, 0, 0, 1, 24'h00a020, 0);
    chk(rd, fx(24'h00a020));
    acc(1, 0, 0, 1, 24'h009010, 24'h001234);
    chk({blk, i_mem_model.flash[12'h808]}, {1'b0, 16'h1234});
    @(posedge clk) dbg_unprotect <= 0;
    acc(0, 1, 0, 1, 24'h00b000, 0);
    chk({blk, i_mem_model.flash[13'h1800]}, {1'b0, 16'hffff});
    $display("test protect done");
    end_of_test;
  end
endmodule // flash_bus_access_test
